/* hw/alc_pkg.sv */
// shared constants for the adaptive logic cell
package alc_pkg;
    // ****************************************
    // operating modes
    // ****************************************
    typedef enum logic [1:0] {
        ALC_NORMAL,
        ALC_EXTENDED,
        ALC_ARITH,
        ALC_SHARED
    } alc_mode_type;

    // ****************************************
    // register bus geometry
    // ****************************************
    localparam int ALC_ADDR_W = 8;
    localparam int ALC_DATA_W = 32;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ALC_CTRL      = 8'h00;
    localparam logic [7:0] ALC_MASK_U_LO = 8'h04;
    localparam logic [7:0] ALC_MASK_U_HI = 8'h08;
    localparam logic [7:0] ALC_MASK_L_LO = 8'h0C;
    localparam logic [7:0] ALC_MASK_L_HI = 8'h10;
    localparam logic [7:0] ALC_STATUS    = 8'h14;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int ALC_F_MODE  = 0;  // two bits
    localparam int ALC_F_RUN   = 2;
    localparam int ALC_F_USRC  = 3;  // two bits
    localparam int ALC_F_LSRC  = 5;  // two bits
    localparam int ALC_F_UASEL = 7;
    localparam int ALC_F_LASEL = 8;
    localparam int ALC_F_CARRY = 9;
    localparam int ALC_CTRL_W  = 10;

    // ****************************************
    // register data sources
    // ****************************************
    localparam logic [1:0] ALC_SRC_FN    = 2'h0;
    localparam logic [1:0] ALC_SRC_PACK  = 2'h1;
    localparam logic [1:0] ALC_SRC_CHAIN = 2'h2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [9:0]  ALC_CTRL_RST = 10'h000;
    localparam logic [31:0] ALC_MASK_RST = 32'h0000_0000;
endpackage

/* hw/alc_cell.sv */
// adaptive logic cell: lookup, adders, two packable registers
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1 - one of four modes at once
// RQ2 - eleven inputs: data, carry, shared, chain
// RQ3 - registers take cluster clock and controls
// RQ4 - normal: two functions or one six-input
// RQ5 - independent four-input pairs, five plus three
// RQ6 - five-input pairs share lut_in_a, lut_in_b
// RQ7 - six-input pair shares a..d, private selects
// RQ8 - upper selects to upper_reg, lower to lower
// RQ9 - packing; async load data from e or f
// RQ10 - lower six-input frees upper pair for packing
// RQ11 - extended: selector between two five-input functions
// RQ12 - extended: eighth input packs, lower_reg unavailable
// RQ13 - arithmetic: four tables, two full adders
// RQ14 - carry in, first, second, carry out
// RQ15 - carry with lookup outputs, sum ignored
// RQ16 - load_select captures load_value, else data
// RQ17 - arithmetic controls come from data inputs
// RQ18 - sync clear and load are cluster-wide
// RQ19 - chains start at first or fifth cell
// RQ20 - long chains continue into next cluster
// RQ21 - shared: sum or carry tables, shared chain
// RQ22 - shared: upper_sel_f, lower_sel_f pack
// RQ23 - async clear beats async load
// RQ24 - mode and tables static while running
module alc_cell (
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // data inputs from local interconnect
    input  wire logic        lut_in_a,
    input  wire logic        lut_in_b,
    input  wire logic        lut_in_c,
    input  wire logic        lut_in_d,
    input  wire logic        upper_sel_e,
    input  wire logic        upper_sel_f,
    input  wire logic        lower_sel_e,
    input  wire logic        lower_sel_f,
    // chain inputs
    input  wire logic        carry_in,
    input  wire logic        shared_in,
    input  wire logic        reg_chain_in,
    // cluster-wide register controls
    input  wire logic        clk_en,
    input  wire logic        async_clear,
    input  wire logic        async_load,
    input  wire logic        sync_clear,
    input  wire logic        load_select,
    input  wire logic [1:0]  load_value,
    // top output drivers
    output logic             top_comb,
    output logic             top_reg,
    // bottom output drivers
    output logic             bottom_comb,
    output logic             bottom_reg,
    // chain outputs
    output logic             carry_out,
    output logic             shared_out,
    output logic             reg_chain_out
);
    // ****************************************
    // configuration storage
    // ****************************************
    logic [9:0]  ctrl;          // mode and routing
    logic [63:0] mask_upper;    // upper table contents
    logic [63:0] mask_lower;    // lower table contents
    logic        upper_q;       // upper_reg storage
    logic        lower_q;       // lower_reg storage

    // decoded control fields
    alc_pkg::alc_mode_type mode;
    logic        run;           // configuration frozen
    logic [1:0]  upper_src;     // upper_reg data source
    logic [1:0]  lower_src;     // lower_reg data source
    logic        upper_asel;    // async data: e or f
    logic        lower_asel;    // async data: e or f
    logic        carry_expose;  // carry on bottom driver, arithmetic mode only

    // RQ1 mode held as one field
    assign mode = alc_pkg::alc_mode_type'(
        ctrl[alc_pkg::ALC_F_MODE +: 2]);
    assign run          = ctrl[alc_pkg::ALC_F_RUN];
    assign upper_src    = ctrl[alc_pkg::ALC_F_USRC +: 2];
    assign lower_src    = ctrl[alc_pkg::ALC_F_LSRC +: 2];
    assign upper_asel   = ctrl[alc_pkg::ALC_F_UASEL];
    assign lower_asel   = ctrl[alc_pkg::ALC_F_LASEL];
    assign carry_expose = ctrl[alc_pkg::ALC_F_CARRY];

    // ****************************************
    // register writes
    // ****************************************
    // RQ24 tables and mode locked while run set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl       <= alc_pkg::ALC_CTRL_RST;
            mask_upper <= {2{alc_pkg::ALC_MASK_RST}};
            mask_lower <= {2{alc_pkg::ALC_MASK_RST}};
        end else if (reg_write) begin
            case (reg_addr)
                alc_pkg::ALC_CTRL: begin
                    // only run may change while running
                    if (run) begin
                        ctrl[alc_pkg::ALC_F_RUN] <= reg_wdata[alc_pkg::ALC_F_RUN];
                    end else begin
                        ctrl <= reg_wdata[9:0];
                    end
                end
                alc_pkg::ALC_MASK_U_LO: begin
                    if (!run) mask_upper[31:0] <= reg_wdata;
                end
                alc_pkg::ALC_MASK_U_HI: begin
                    if (!run) mask_upper[63:32] <= reg_wdata;
                end
                alc_pkg::ALC_MASK_L_LO: begin
                    if (!run) mask_lower[31:0] <= reg_wdata;
                end
                alc_pkg::ALC_MASK_L_HI: begin
                    if (!run) mask_lower[63:32] <= reg_wdata;
                end
                default: begin
                    // unmapped or read-only: ignored
                end
            endcase
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    // read data stands one cycle after strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                alc_pkg::ALC_CTRL:      reg_rdata <= {22'h00_0000, ctrl};
                alc_pkg::ALC_MASK_U_LO: reg_rdata <= mask_upper[31:0];
                alc_pkg::ALC_MASK_U_HI: reg_rdata <= mask_upper[63:32];
                alc_pkg::ALC_MASK_L_LO: reg_rdata <= mask_lower[31:0];
                alc_pkg::ALC_MASK_L_HI: reg_rdata <= mask_lower[63:32];
                alc_pkg::ALC_STATUS: begin
                    // live view of the cell outputs
                    reg_rdata <= {25'h000_0000, reg_chain_out, shared_out, carry_out,
                        bottom_reg, bottom_comb, top_reg, top_comb};
                end
                default:                reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // lookup tables
    // ****************************************
    logic [5:0] idx_upper;   // upper six-input index
    logic [5:0] idx_lower;   // lower six-input index
    logic       fn_upper;    // upper six-input result
    logic       fn_lower;    // lower six-input result
    logic       fn_ext0;     // five-input, upper_sel_e
    logic       fn_ext1;     // five-input, lower_sel_e
    logic       fn_ext;      // seven-input result
    logic [3:0] quad;        // four four-input tables

    // RQ7 shared a..d, private select pairs
    assign idx_upper = {upper_sel_f, upper_sel_e, lut_in_d, lut_in_c, lut_in_b, lut_in_a};
    assign idx_lower = {lower_sel_f, lower_sel_e, lut_in_d, lut_in_c, lut_in_b, lut_in_a};
    // RQ4 each half is a full six-input table
    // RQ5 smaller or independent functions by contents
    // RQ6 five-input pairs share lut_in_a, lut_in_b
    assign fn_upper = mask_upper[idx_upper];
    assign fn_lower = mask_lower[idx_lower];

    // RQ11 two five-input functions, four shared
    assign fn_ext0 = mask_upper[idx_upper[4:0]];
    assign fn_ext1 = mask_lower[idx_lower[4:0]];
    assign fn_ext  = upper_sel_f ? fn_ext1 : fn_ext0;

    // RQ13 four tables, all share a and b
    // RQ17 counter controls fed on shared inputs
    assign quad[0] = mask_upper[{upper_sel_e, lut_in_c, lut_in_b, lut_in_a}];
    assign quad[1] = mask_upper[{2'h1, upper_sel_e, lut_in_d, lut_in_b, lut_in_a}];
    assign quad[2] = mask_lower[{lower_sel_e, lut_in_c, lut_in_b, lut_in_a}];
    assign quad[3] = mask_lower[{2'h1, lower_sel_e, lut_in_d, lut_in_b, lut_in_a}];

    // ****************************************
    // dedicated adders
    // ****************************************
    logic first_a;      // first_adder operand a
    logic first_b;      // first_adder operand b
    logic first_sum;    // first_adder sum
    logic first_cy;     // first_adder carry
    logic second_a;     // second_adder operand a
    logic second_b;     // second_adder operand b
    logic second_sum;   // second_adder sum
    logic second_cy;    // second_adder carry

    // operand routing per arithmetic flavour
    always_comb begin
        if (mode == alc_pkg::ALC_SHARED) begin
            // RQ21 sum table plus incoming shared carry
            first_a  = quad[0];
            first_b  = shared_in;
            second_a = quad[2];
            second_b = quad[1];
        end else begin
            // RQ13 each adder sums two tables
            first_a  = quad[0];
            first_b  = quad[1];
            second_a = quad[2];
            second_b = quad[3];
        end
    end

    // RQ14 carry_in, first, second, carry_out
    assign first_sum  = first_a ^ first_b ^ carry_in;
    assign first_cy   = (first_a & first_b)
        | (carry_in & (first_a ^ first_b));
    assign second_sum = second_a ^ second_b ^ first_cy;
    assign second_cy  = (second_a & second_b)
        | (first_cy & (second_a ^ second_b));

    // chain outputs
    // RQ19 chain heads are set by carry_in wiring
    // RQ20 carry_out drives next cell or cluster
    assign carry_out = (mode == alc_pkg::ALC_ARITH
        || mode == alc_pkg::ALC_SHARED)
        ? second_cy : 1'b0;
    // RQ21 carry table feeds the next first_adder
    assign shared_out = (mode == alc_pkg::ALC_SHARED) ? quad[3] : 1'b0;

    // ****************************************
    // per-mode combinational results
    // ****************************************
    logic next_top;     // top driver value
    logic next_bottom;  // bottom driver value
    logic pack_upper;   // packing input, upper_reg
    logic pack_lower;   // packing input, lower_reg
    logic lower_ok;     // lower_reg usable

    // route results by mode
    always_comb begin
        next_top    = 1'b0;
        next_bottom = 1'b0;
        pack_upper  = upper_sel_f;
        pack_lower  = lower_sel_f;
        lower_ok    = 1'b1;
        case (mode)
            alc_pkg::ALC_NORMAL: begin
                // RQ8 upper pair top, lower pair bottom
                next_top    = fn_upper;
                next_bottom = fn_lower;
                // RQ10 lower_sel_f packs only unregistered
                if (lower_src == alc_pkg::ALC_SRC_FN) begin
                    pack_lower = 1'b0;
                end
            end
            alc_pkg::ALC_EXTENDED: begin
                // RQ12 eighth input packs, no lower_reg
                next_top   = fn_ext;
                pack_upper = lower_sel_f;
                lower_ok   = 1'b0;
            end
            alc_pkg::ALC_ARITH: begin
                next_top = first_sum;
                // RQ15 carry shown, sum disregarded
                if (carry_expose) begin
                    next_bottom = second_cy;
                end else begin
                    next_bottom = second_sum;
                end
            end
            alc_pkg::ALC_SHARED: begin
                // RQ22 upper_sel_f, lower_sel_f pack
                next_top    = first_sum;
                next_bottom = second_sum;
            end
            default: next_top = 1'b0;
        endcase
    end

    // ****************************************
    // register data selection
    // ****************************************
    logic next_upper_d;  // upper_reg data input
    logic next_lower_d;  // lower_reg data input
    logic upper_adata;   // upper async load data
    logic lower_adata;   // lower async load data

    // RQ9 packing pin or function or chain
    always_comb begin
        case (upper_src)
            alc_pkg::ALC_SRC_PACK:  next_upper_d = pack_upper;
            alc_pkg::ALC_SRC_CHAIN: next_upper_d = reg_chain_in;
            default:                next_upper_d = next_top;
        endcase
        case (lower_src)
            alc_pkg::ALC_SRC_PACK:  next_lower_d = pack_lower;
            alc_pkg::ALC_SRC_CHAIN: next_lower_d = upper_q;
            default:                next_lower_d = next_bottom;
        endcase
    end

    // RQ9 async load data from e or f input
    assign upper_adata = upper_asel ? upper_sel_f : upper_sel_e;
    assign lower_adata = lower_asel ? lower_sel_f : lower_sel_e;

    // ****************************************
    // packable registers
    // ****************************************
    // RQ3 clear async, enable, sync clear, sync load
    // RQ18 sync_clear and load_select are shared
    always_ff @(posedge clk or posedge rst
                or posedge async_clear) begin
        if (rst || async_clear) begin
            upper_q <= 1'b0;
        end else if (async_load) begin
            // held load keeps storage in step
            upper_q <= upper_adata;
        end else if (clk_en) begin
            if (sync_clear) begin
                upper_q <= 1'b0;
            end else if (load_select) begin
                // RQ16 capture load_value
                upper_q <= load_value[0];
            end else begin
                upper_q <= next_upper_d;
            end
        end
    end

    // lower_reg forced clear when unavailable
    always_ff @(posedge clk or posedge rst
                or posedge async_clear) begin
        if (rst || async_clear) begin
            lower_q <= 1'b0;
        end else if (!lower_ok) begin
            lower_q <= 1'b0;
        end else if (async_load) begin
            lower_q <= lower_adata;
        end else if (clk_en) begin
            if (sync_clear) begin
                lower_q <= 1'b0;
            end else if (load_select) begin
                // RQ16 capture load_value
                lower_q <= load_value[1];
            end else begin
                lower_q <= next_lower_d;
            end
        end
    end

    // ****************************************
    // output drivers
    // ****************************************
    // RQ23 clear wins over async load
    assign top_reg = async_clear ? 1'b0 : (async_load ? upper_adata : upper_q);
    assign bottom_reg = (async_clear || !lower_ok)
        ? 1'b0
        : (async_load ? lower_adata : lower_q);
    // RQ8 bypass paths on top and bottom
    assign top_comb      = next_top;
    assign bottom_comb   = next_bottom;
    // RQ2 register chain to next cell
    assign reg_chain_out = lower_ok ? lower_q : upper_q;
endmodule

`default_nettype wire

/* test/alc_cell_properties.sv */
// port assertions for the adaptive logic cell
`timescale 1ns/1ps
`default_nettype none
module alc_cell_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        upper_sel_e,
    input wire logic        upper_sel_f,
    input wire logic        clk_en,
    input wire logic        async_clear,
    input wire logic        async_load,
    input wire logic        sync_clear,
    input wire logic        load_select,
    input wire logic [1:0]  load_value,
    input wire logic        top_comb,
    input wire logic        top_reg,
    input wire logic        bottom_comb,
    input wire logic        bottom_reg,
    input wire logic        carry_out,
    input wire logic        shared_out,
    input wire logic        reg_chain_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // status word as read back
    logic [6:0] status_view;
    assign status_view = {reg_chain_out, shared_out, carry_out, bottom_reg, bottom_comb,
                          top_reg, top_comb};

    // ****************************************
    // request sequences
    // ****************************************
    // no asynchronous override at this edge
    sequence quiet_s;
        !async_clear && !async_load;
    endsequence
    // enabled synchronous load, not cleared
    sequence load_s;
        quiet_s ##0 (clk_en && load_select && !sync_clear);
    endsequence
    // enabled synchronous clear
    sequence clear_s;
        quiet_s ##0 (clk_en && sync_clear);
    endsequence

    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    status_view_a: assert property (
        reg_read && reg_addr == alc_pkg::ALC_STATUS |=> reg_rdata[6:0] == $past(status_view))
        else $error("status word differs from outputs");
    sync_load_a: assert property (load_s ##1 quiet_s |-> top_reg == $past(load_value[0]))
        else $error("upper register missed its load value");
    sync_clear_a: assert property (clear_s ##1 quiet_s |-> !top_reg && !bottom_reg)
        else $error("registers not cleared synchronously");
    enable_hold_a: assert property (
        quiet_s ##0 !clk_en ##1 quiet_s |-> $stable(top_reg) && $stable(bottom_reg))
        else $error("register changed with clock enable low");
    clear_wins_a: assert property (async_clear |-> !top_reg && !bottom_reg)
        else $error("asynchronous clear did not win");
    async_data_a: assert property (
        async_load && !async_clear && upper_sel_e == upper_sel_f |-> top_reg == upper_sel_e)
        else $error("asynchronous load data wrong");
    clear_release_a: assert property (
        $fell(async_clear) && !async_load |-> !top_reg && !bottom_reg)
        else $error("register not zero after clear released");
endmodule

bind alc_cell alc_cell_properties u_props (
    .clk, .rst, .reg_addr, .reg_read, .reg_rdata, .upper_sel_e, .upper_sel_f,
    .clk_en, .async_clear, .async_load, .sync_clear, .load_select, .load_value,
    .top_comb, .top_reg, .bottom_comb, .bottom_reg, .carry_out, .shared_out,
    .reg_chain_out
);
`default_nettype wire

/* test/alc_neighbor.sv */
// model of the preceding cell: its chain outputs
`timescale 1ns/1ps
`default_nettype none
module alc_neighbor (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] cmd,          // {register chain, shared, carry}
    output logic            carry_in,
    output logic            shared_in,
    output logic            reg_chain_in
);
    // carry leaves the neighbour from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carry_in     <= 1'b0;
            shared_in    <= 1'b0;
            reg_chain_in <= 1'b0;
        end else begin
            carry_in     <= cmd[0];
            shared_in    <= cmd[1];
            reg_chain_in <= cmd[2];
        end
    end
endmodule
`default_nettype wire

/* test/adaptive_logic_cell_modes_tb.sv */
// self-checking bench for the adaptive logic cell
`timescale 1ns/1ps
`default_nettype none
module adaptive_logic_cell_modes_tb;
    localparam logic [63:0] MU = 64'h9E37_79B9_7F4A_7C15;  // upper table
    localparam logic [63:0] ML = 64'hC2B2_AE3D_27D4_EB4F;  // lower table
    logic        clk, rst, reg_write, reg_read;
    logic [7:0]  reg_addr, din;
    logic [31:0] reg_wdata, reg_rdata, w;
    logic [2:0]  nb_cmd;
    logic        carry_in, shared_in, reg_chain_in;
    logic        clk_en, async_clear, async_load, sync_clear, load_select;
    logic [1:0]  load_value;
    logic        top_comb, top_reg, bottom_comb, bottom_reg;
    logic        carry_out, shared_out, reg_chain_out;
    int          mismatches, samples_checked;

    alc_cell dut (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .lut_in_a(din[0]), .lut_in_b(din[1]), .lut_in_c(din[2]), .lut_in_d(din[3]),
        .upper_sel_e(din[4]), .upper_sel_f(din[5]),
        .lower_sel_e(din[6]), .lower_sel_f(din[7]),
        .carry_in, .shared_in, .reg_chain_in, .clk_en, .async_clear, .async_load,
        .sync_clear, .load_select, .load_value, .top_comb, .top_reg, .bottom_comb,
        .bottom_reg, .carry_out, .shared_out, .reg_chain_out
    );
    alc_neighbor u_nb (.clk, .rst, .cmd(nb_cmd), .carry_in, .shared_in, .reg_chain_in);

    always #12.5 clk = ~clk;

    // ****************************************
    // checking and bus helpers
    // ****************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // stop the cell, then load the new control word
    task automatic set_ctrl(input logic [31:0] v);
        wr(alc_pkg::ALC_CTRL, 32'h0000_0000);
        wr(alc_pkg::ALC_CTRL, v);
    endtask
    // one capture edge, then look at settled outputs
    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // reset values, masks refused while running
    task automatic test_regs;
        for (int a = 0; a <= 24; a += 4) begin
            rd(8'(a), w);
            chk_word(w, 32'h0000_0000);
        end
        wr(alc_pkg::ALC_MASK_U_LO, MU[31:0]);
        wr(alc_pkg::ALC_MASK_U_HI, MU[63:32]);
        wr(alc_pkg::ALC_MASK_L_LO, ML[31:0]);
        wr(alc_pkg::ALC_MASK_L_HI, ML[63:32]);
        set_ctrl(32'h0000_0004);
        wr(alc_pkg::ALC_MASK_U_LO, 32'h0000_0000);
        rd(alc_pkg::ALC_MASK_U_LO, w);
        chk_word(w, MU[31:0]);
    endtask
    // two six-input functions and their registers
    task automatic test_normal;
        clk_en <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            din <= 8'(i);
            @(negedge clk);
            chk_bit(top_comb, MU[din[5:0]]);
            chk_bit(bottom_comb, ML[{din[7:6], din[3:0]}]);
            if (i > 0) chk_bit(top_reg, MU[6'(i - 1)]);
            if (i > 0) chk_bit(bottom_reg, ML[{2'(i - 1 >> 6), 4'(i - 1)}]);
        end
        settle();
        rd(alc_pkg::ALC_STATUS, w);
        chk_word(w, {25'h000_0000, ML[63], 2'b00, ML[63], ML[63], MU[63], MU[63]});
    endtask
    // seven-input selector, lower register held off
    task automatic test_extended;
        set_ctrl(32'h0000_0005);
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            din <= 8'(i);
            @(negedge clk);
            chk_bit(top_comb, din[5] ? ML[{din[6], din[3:0]}] : MU[{din[4], din[3:0]}]);
            chk_bit(bottom_reg, 1'b0);
        end
    endtask
    // arithmetic, carry view and shared arithmetic
    task automatic test_arith;
        logic [31:0] cfg [3] = '{32'h0000_0006, 32'h0000_0206, 32'h0000_0007};
        logic q0, q1, q2, q3, sh;
        logic [1:0] s1, s2;
        for (int m = 0; m < 3; m++) begin
            set_ctrl(cfg[m]);
            sh = (m == 2);
            for (int i = 0; i < 1024; i++) begin
                @(posedge clk);
                din <= 8'(i);
                nb_cmd <= {1'b0, 2'(i >> 8)};
                @(negedge clk);
                q0 = MU[{2'b00, din[4], din[2:0]}];
                q1 = MU[{2'b01, din[4], din[3], din[1:0]}];
                q2 = ML[{2'b00, din[6], din[2:0]}];
                q3 = ML[{2'b01, din[6], din[3], din[1:0]}];
                s1 = {1'b0, q0} + (sh ? shared_in : q1) + carry_in;
                s2 = {1'b0, q2} + (sh ? q1 : q3) + s1[1];
                chk_bit(top_comb, s1[0]);
                chk_bit(bottom_comb, (m == 1) ? s2[1] : s2[0]);
                chk_bit(carry_out, s2[1]);
                chk_bit(shared_out, sh ? q3 : 1'b0);
            end
        end
    endtask
    // load, clears, enable and chain source on the registers
    task automatic test_ctrl_regs;
        set_ctrl(32'h0000_0044);
        @(posedge clk);
        {load_select, load_value, din} <= {3'b110, 8'h00};
        settle();
        chk_bit(top_reg, 1'b0);
        chk_bit(bottom_reg, 1'b1);
        sync_clear <= 1'b1;
        settle();
        chk_bit(bottom_reg, 1'b0);
        {sync_clear, clk_en, load_value} <= 4'b0011;
        settle();
        chk_bit(top_reg, 1'b0);
        {clk_en, load_select, nb_cmd} <= 5'b10100;
        settle();
        settle();
        chk_bit(bottom_reg, 1'b1);
        chk_bit(reg_chain_out, 1'b1);
        @(posedge clk);
        {async_load, din} <= {1'b1, 8'h30};
        @(negedge clk);
        chk_bit(top_reg, 1'b1);
        async_clear <= 1'b1;
        @(negedge clk);
        chk_bit(top_reg, 1'b0);
        {async_clear, async_load, clk_en} <= 3'b000;
        settle();
        chk_bit(top_reg, 1'b0);
    endtask

    task automatic finish_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: run needs under 8000 cycles
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end

    initial begin
        {clk, reg_write, reg_read, reg_addr, reg_wdata, din, nb_cmd} = '0;
        {clk_en, async_clear, async_load, sync_clear, load_select, load_value} = '0;
        mismatches = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_normal();
        test_extended();
        test_arith();
        test_ctrl_regs();
        finish_test();
    end
endmodule
`default_nettype wire
